// ### acc_pkg.sv
`default_nettype none

package acc_pkg;

   // Serial frame layout
   localparam int FRAME_BITS = 32;
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
   localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
   localparam logic [CNT_W-1:0] CNT_LAST_BIT = 6'h1F;
   localparam int IDX_W = 5;
   localparam int RESULT_W = 24;
   localparam int SUB_W = 5;

   // Out-of-range codes
   localparam logic [RESULT_W-1:0] OVER_VALUE = 24'h800000;
   localparam logic [SUB_W-1:0] OVER_SUB = 5'h00;
   localparam logic [RESULT_W-1:0] UNDER_VALUE = 24'h7FFFFF;
   localparam logic [SUB_W-1:0] UNDER_SUB = 5'h1F;

   // Synchroniser lanes
   localparam int SYNC_W = 4;
   localparam int SY_CS = 0;
   localparam int SY_SCK = 1;
   localparam int SY_SUP = 2;
   localparam int SY_DONE = 3;
   localparam logic [SYNC_W-1:0] SYNC_RST = 4'h3;

   // Timing
   localparam int MCLK_PERIOD_NS = 8;
   localparam int POR_TIME_NS = 500000;
   localparam int POR_CYCLES_DEF = (POR_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int CONV_CYCLES_DEF = 2000;
   localparam int CAL_CYCLES_DEF = 200;
   localparam int SCK_HALF_DEF = 4;

   typedef enum logic [1:0] {
      ST_POR,
      ST_CONV,
      ST_SLEEP,
      ST_OUT
   } acc_state_e;

   typedef struct packed {
      logic over;
      logic under;
      logic sign;
      logic [RESULT_W-1:0] value;
      logic [SUB_W-1:0] sub;
   } acc_sample_s;

   typedef struct packed {
      logic por_active;
      logic converting;
      logic cal_active;
      logic low_power;
      logic int_sck_mode;
   } acc_status_s;

   // Frame: done flag, filler, sign, result, sub bits
   function automatic logic [FRAME_BITS-1:0] acc_build_frame(input acc_sample_s s);
      logic [FRAME_BITS-1:0] f;
      f = {1'b0, 1'b0, s.sign, s.value, s.sub};
      if (s.over)
      begin
         f = {1'b0, 1'b0, 1'b1, OVER_VALUE, OVER_SUB};
      end
      else if (s.under)
      begin
         f = {1'b0, 1'b0, 1'b0, UNDER_VALUE, UNDER_SUB};
      end
      return f;
   endfunction

endpackage

`default_nettype wire

// ### acc_link_shift.sv
`default_nettype none

module acc_link_shift
   import acc_pkg::*;
(
   // Link clock and frame select
   input wire logic i_sck_clk,
   input wire logic i_cs_n,
   // Word and status from the main domain
   input wire logic [FRAME_BITS-1:0] i_frame,
   input wire logic i_eoc_n,
   // Serial side
   output logic o_sdo,
   output logic o_done
);

   logic [CNT_W-1:0] cnt_ff;
   logic bit_ff;
   logic done_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic [IDX_W-1:0] nxt_idx;

   // A fall after a full frame starts the next frame
   always_comb
   begin
      if (cnt_ff == CNT_FULL)
      begin
         nxt_cnt = CNT_ONE;
      end
      else
      begin
         nxt_cnt = CNT_W'(cnt_ff + CNT_ONE);
      end
      nxt_idx = IDX_W'(CNT_LAST_BIT - nxt_cnt);
   end

   // Frame ends with chip select high
   always_ff @(negedge i_sck_clk or posedge i_cs_n)
   begin
      if (i_cs_n)
      begin
         cnt_ff <= CNT_ZERO;
         bit_ff <= 1'b1;
         done_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         bit_ff <= i_frame[nxt_idx];
         done_ff <= (nxt_cnt == CNT_FULL);
      end
   end

   // Before the first fall and after the last, show live status
   assign o_sdo = ((cnt_ff == CNT_ZERO) || (cnt_ff == CNT_FULL)) ? i_eoc_n : bit_ff;
   assign o_done = done_ff;

endmodule // acc_link_shift

`default_nettype wire

// ### acc_conv_ctrl.sv
`default_nettype none

module acc_conv_ctrl
   import acc_pkg::*;
#(
   parameter int POR_CYCLES = POR_CYCLES_DEF,
   parameter int CONV_CYCLES = CONV_CYCLES_DEF,
   parameter int CAL_CYCLES = CAL_CYCLES_DEF,
   parameter int SCK_HALF = SCK_HALF_DEF
)
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Supply monitor
   input wire logic i_supply_ok,
   // Serial pins; i_sck is the pin level and the link clock
   input wire logic i_cs_n,
   input wire logic i_sck,
   output logic o_sck,
   output logic o_sck_oe,
   output logic o_sdo,
   output logic o_sdo_oe,
   // Filter result
   input wire acc_sample_s i_sample,
   // Status
   output acc_status_s o_status,
   output logic o_sample_take
);

   localparam int PW = $clog2(POR_CYCLES + 1);
   localparam int CW = $clog2(CONV_CYCLES + CAL_CYCLES + 1);
   localparam int DW = $clog2(SCK_HALF + 1);
   localparam logic [PW-1:0] POR_LAST = PW'(POR_CYCLES - 1);
   localparam logic [CW-1:0] MEAS_LAST = CW'(CONV_CYCLES - 1);
   localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES + CAL_CYCLES - 1);
   localparam logic [DW-1:0] HALF_LAST = DW'(SCK_HALF - 1);

   // Synchronised pins
   logic [SYNC_W-1:0] sync1_ff;
   logic [SYNC_W-1:0] sync2_ff;
   logic cs_d_ff;
   logic done_d_ff;
   logic cs_s;
   logic sck_s;
   logic sup_s;
   logic done_s;
   logic cs_fall;
   logic link_end;

   // Sequencing
   acc_state_e state_ff;
   acc_state_e nxt_state;
   logic [PW-1:0] por_cnt_ff;
   logic [CW-1:0] phase_cnt_ff;
   logic cal_ff;
   logic conv_end;
   logic out_end;

   // Result and status
   logic [FRAME_BITS-1:0] frame_ff;
   logic eoc_n_ff;
   logic sdo_oe_ff;
   logic take_ff;
   logic int_mode_ff;
   acc_status_s status_ff;

   // Internal serial clock
   logic [DW-1:0] div_cnt_ff;
   logic sck_ff;
   logic sck_oe_ff;
   logic [CNT_W-1:0] ifall_cnt_ff;
   logic int_run;
   logic int_end;

   logic link_done;
   logic link_en_ff;

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         sync1_ff <= SYNC_RST;
         sync2_ff <= SYNC_RST;
         cs_d_ff <= 1'b1;
         done_d_ff <= 1'b0;
      end
      else
      begin
         sync1_ff <= {link_done, i_supply_ok, i_sck, i_cs_n};
         sync2_ff <= sync1_ff;
         cs_d_ff <= cs_s;
         done_d_ff <= done_s;
      end
   end

   assign cs_s = sync2_ff[SY_CS];
   assign sck_s = sync2_ff[SY_SCK];
   assign sup_s = sync2_ff[SY_SUP];
   assign done_s = sync2_ff[SY_DONE];

   assign cs_fall = cs_d_ff && !cs_s;
   assign link_end = done_s && !done_d_ff;
   assign conv_end = (state_ff == ST_CONV) && (phase_cnt_ff == CONV_LAST);
   assign int_end = (ifall_cnt_ff == CNT_FULL);
   assign out_end = cs_s || link_end || (int_mode_ff && int_end);

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_POR:
         begin
            if (por_cnt_ff == POR_LAST)
            begin
               nxt_state = ST_CONV;
            end
         end
         ST_CONV:
         begin
            if (conv_end)
            begin
               nxt_state = ST_SLEEP;
            end
         end
         ST_SLEEP:
         begin
            if (!cs_s)
            begin
               nxt_state = ST_OUT;
            end
         end
         ST_OUT:
         begin
            if (out_end)
            begin
               nxt_state = ST_CONV;
            end
         end
         default:
         begin
            nxt_state = ST_POR;
         end
      endcase
      if (!sup_s)
      begin
         nxt_state = ST_POR;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         state_ff <= ST_POR;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // Reset pulse counter, restarts while supply is low
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         por_cnt_ff <= '0;
      end
      else if ((state_ff != ST_POR) || !sup_s)
      begin
         por_cnt_ff <= '0;
      end
      else if (por_cnt_ff != POR_LAST)
      begin
         por_cnt_ff <= PW'(por_cnt_ff + 1'b1);
      end
   end

   // Measurement phase, then full-scale calibration; no offset phase
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         phase_cnt_ff <= '0;
         cal_ff <= 1'b0;
      end
      else if (state_ff != ST_CONV)
      begin
         phase_cnt_ff <= '0;
         cal_ff <= 1'b0;
      end
      else
      begin
         phase_cnt_ff <= CW'(phase_cnt_ff + 1'b1);
         if (phase_cnt_ff == MEAS_LAST)
         begin
            cal_ff <= 1'b1;
         end
         else if (conv_end)
         begin
            cal_ff <= 1'b0;
         end
      end
   end

   // Result word captured once per conversion, static until next one or power reset
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         frame_ff <= '0;
         take_ff <= 1'b0;
      end
      else if (state_ff == ST_POR)
      begin
         frame_ff <= '0;
         take_ff <= 1'b0;
      end
      else
      begin
         take_ff <= conv_end;
         if (conv_end)
         begin
            frame_ff <= acc_build_frame(i_sample);
         end
      end
   end

   // Done flag and data pin drive, which follows chip select
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         eoc_n_ff <= 1'b1;
         sdo_oe_ff <= 1'b0;
      end
      else
      begin
         eoc_n_ff <= (nxt_state == ST_CONV) || (nxt_state == ST_POR);
         sdo_oe_ff <= !cs_s && sup_s && (state_ff != ST_POR);
      end
   end

   // Clock source from clock pin level, sampled only from pins
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         int_mode_ff <= 1'b0;
      end
      else if ((state_ff == ST_POR) && (nxt_state == ST_CONV))
      begin
         int_mode_ff <= sck_s;
      end
      else if (cs_fall && (state_ff != ST_POR))
      begin
         int_mode_ff <= sck_s;
      end
   end

   // Internal serial clock: 32 pulses, idle low, rise first
   assign int_run = int_mode_ff && (state_ff == ST_OUT) && !cs_s && !int_end;

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         div_cnt_ff <= '0;
         sck_ff <= 1'b0;
         ifall_cnt_ff <= CNT_ZERO;
      end
      else if (!int_run)
      begin
         div_cnt_ff <= '0;
         sck_ff <= 1'b0;
         if (state_ff != ST_OUT)
         begin
            ifall_cnt_ff <= CNT_ZERO;
         end
      end
      else if (div_cnt_ff == HALF_LAST)
      begin
         div_cnt_ff <= '0;
         sck_ff <= !sck_ff;
         if (sck_ff)
         begin
            ifall_cnt_ff <= CNT_W'(ifall_cnt_ff + CNT_ONE);
         end
      end
      else
      begin
         div_cnt_ff <= DW'(div_cnt_ff + 1'b1);
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         sck_oe_ff <= 1'b0;
         link_en_ff <= 1'b0;
      end
      else
      begin
         sck_oe_ff <= int_mode_ff && (state_ff == ST_OUT) && !cs_s;
         link_en_ff <= (state_ff == ST_OUT) && (!int_mode_ff || sck_oe_ff);
      end
   end

   // Status word
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         status_ff <= '0;
      end
      else
      begin
         status_ff.por_active <= (nxt_state == ST_POR);
         status_ff.converting <= (nxt_state == ST_CONV);
         status_ff.cal_active <= cal_ff;
         status_ff.low_power <= (nxt_state == ST_SLEEP) && cs_s;
         status_ff.int_sck_mode <= int_mode_ff;
      end
   end

   // Link-side shifter on the serial clock pin
   acc_link_shift u_link (
      .i_sck_clk(i_sck),
      .i_cs_n(i_cs_n || !link_en_ff), // Pull-up to driven low is no shift edge
      .i_frame(frame_ff),
      .i_eoc_n(eoc_n_ff),
      .o_sdo(o_sdo),
      .o_done(link_done)
   );

   assign o_sck = sck_ff;
   assign o_sck_oe = sck_oe_ff;
   assign o_sdo_oe = sdo_oe_ff;
   assign o_status = status_ff;
   assign o_sample_take = take_ff;

endmodule // acc_conv_ctrl

`default_nettype wire

// ### acc_conv_ctrl_properties.sv
`default_nettype none

module acc_conv_ctrl_properties
   import acc_pkg::*;
(
   // Clock, reset, supply
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_supply_ok,
   // Serial pins
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic o_sck,
   input wire logic o_sck_oe,
   input wire logic o_sdo,
   input wire logic o_sdo_oe,
   // Result and status
   input wire acc_sample_s i_sample,
   input wire acc_status_s o_status,
   input wire logic o_sample_take
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);

   sequence s_cs_idle;
      i_cs_n [*4];
   endsequence

   sequence s_supply_lost;
      !i_supply_ok [*4];
   endsequence

   chk_sdo_float: assert property (s_cs_idle |-> !o_sdo_oe)
      else $error("sdo driven while cs high");
   chk_supply_por: assert property (s_supply_lost |=> o_status.por_active)
      else $error("no reset on low supply");
   chk_take_once: assert property (o_sample_take |=> !o_sample_take)
      else $error("result taken twice");
   chk_take_sleep: assert property (o_sample_take |=> !o_status.converting)
      else $error("no sleep after conversion");
   chk_sleep_quiet: assert property (o_status.low_power |-> !o_status.converting && !o_sck_oe)
      else $error("low power outside sleep");
   chk_por_quiet: assert property (o_status.por_active [*2] |-> !o_sdo_oe && !o_sample_take)
      else $error("activity during power reset");
   chk_cal_start: assert property ($rose(o_status.cal_active) |-> o_status.converting)
      else $error("calibration outside conversion");
   chk_eoc_high: assert property (o_status.converting [*6] ##0 o_sdo_oe |-> o_sdo)
      else $error("done flag low while converting");
   chk_int_sck: assert property (o_sck_oe |-> o_status.int_sck_mode)
      else $error("clock driven in external mode");
endmodule // acc_conv_ctrl_properties

bind acc_conv_ctrl acc_conv_ctrl_properties chk_i (
   .i_mclk(i_mclk),
   .i_nrst(i_nrst),
   .i_supply_ok(i_supply_ok),
   .i_cs_n(i_cs_n),
   .i_sck(i_sck),
   .o_sck(o_sck),
   .o_sck_oe(o_sck_oe),
   .o_sdo(o_sdo),
   .o_sdo_oe(o_sdo_oe),
   .i_sample(i_sample),
   .o_status(o_status),
   .o_sample_take(o_sample_take)
);

`default_nettype wire

// ### acc_host_model.sv
`default_nettype none

module acc_host_model
(
   // Host drive
   output logic o_cs_n,
   output logic o_sck,
   output logic o_sck_oe,
   // Resolved pins
   input wire logic i_sck,
   input wire logic i_sdo,
   input wire logic i_sdo_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_sck_oe = 1'b1;
   end

   task automatic wait_sck(input logic v, inout logic ok);
      int j;
      for (j = 0; j < 200 && i_sck !== v; j++)
         #1;
      ok &= (i_sck === v);
   endtask

   // Host clock at 15 ns when ext, else follows device clock
   task automatic read(input logic ext, input int nb, output logic [31:0] w, output logic ok);
      int k;
      w = 32'h0;
      o_sck_oe = ext;
      #60 o_cs_n = 1'b0;
      for (k = 0; k < 9000 && !(i_sdo_oe === 1'b1 && i_sdo === 1'b0); k++)
         #8;
      ok = (k < 9000);
      for (k = 0; k < nb && ok; k++)
      begin
         if (ext)
            #7.5 o_sck = 1'b1;
         else
         begin
            wait_sck(1'b0, ok);
            wait_sck(1'b1, ok);
         end
         w[31 - k] = i_sdo;
         if (ext)
            #7.5 o_sck = 1'b0;
      end
      #60 o_cs_n = 1'b1;
      o_sck_oe = 1'b1;
   endtask
endmodule // acc_host_model

`default_nettype wire

// ### testbench.sv
`default_nettype none

module testbench
   import acc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic i_mclk, i_nrst, i_supply_ok, o_sck, o_sck_oe, o_sdo, o_sdo_oe, o_sample_take;
   logic h_cs_n, h_sck, h_sck_oe, sck_w, sdo_w, ok;
   acc_sample_s i_sample, held;
   acc_status_s o_status;
   logic [31:0] word, m;
   int err_count = 0;
   int n_checks = 0;
   int seed = 95493;
   int i;

   // Clock pin pull-up; released data shows no stale value
   assign sck_w = o_sck_oe ? o_sck : (h_sck_oe ? h_sck : 1'b1);
   assign sdo_w = o_sdo_oe ? o_sdo : ~o_sdo;

   initial
   begin
      i_mclk = 1'b0;
      forever
         #4 i_mclk = ~i_mclk;
   end

   acc_conv_ctrl #(.POR_CYCLES(20), .CONV_CYCLES(40), .CAL_CYCLES(8), .SCK_HALF(4))
   acc_conv_ctrl_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_supply_ok(i_supply_ok),
      .i_cs_n(h_cs_n), .i_sck(sck_w), .o_sck(o_sck), .o_sck_oe(o_sck_oe), .o_sdo(o_sdo),
      .o_sdo_oe(o_sdo_oe), .i_sample(i_sample), .o_status(o_status),
      .o_sample_take(o_sample_take));

   acc_host_model acc_host_model_i (.o_cs_n(h_cs_n), .o_sck(h_sck), .o_sck_oe(h_sck_oe),
      .i_sck(sck_w), .i_sdo(sdo_w), .i_sdo_oe(o_sdo_oe));

   function automatic logic [31:0] exp_frame(input acc_sample_s s);
      if (s.over)
         return {3'h1, 24'h800000, 5'h00};
      if (s.under)
         return {3'h0, 24'h7FFFFF, 5'h1F};
      return {2'h0, s.sign, s.value, s.sub};
   endfunction

   task automatic chk_frame(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic chk_flag(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("mismatch %s exp %b got %b", nm, e, g);
      end
   endtask

   task automatic end_sim;
      if (err_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge i_mclk);
   endtask

   task automatic new_sample(input int c);
      @(negedge i_mclk);
      i_sample = acc_sample_s'($random(seed));
      i_sample.over = (c == 0);
      i_sample.under = (c == 1);
      held = i_sample;
   endtask

   // Junk on the filter bus once the result is taken
   task automatic wait_take;
      int k;
      for (k = 0; k < 500 && o_sample_take !== 1'b1; k++)
         @(negedge i_mclk);
      if (k == 500)
      begin
         err_count++;
         end_sim();
      end
      @(negedge i_mclk);
      i_sample = ~held;
   endtask

   initial
   begin
      i_nrst = 1'b0;
      i_supply_ok = 1'b1;
      i_sample = acc_sample_s'(32'h0);
      new_sample(0);
      cyc(3);
      i_nrst = 1'b1;
      cyc(2);
      chk_flag("por_active", 1'b1, o_status.por_active);
      for (i = 0; i < 8; i++)
      begin
         if (i > 0)
            new_sample(i);
         wait_take();
         cyc(4);
         chk_flag("low_power", 1'b1, o_status.low_power);
         acc_host_model_i.read(i[0], (i == 3) ? 9 : 32, word, ok);
         if (!ok)
         begin
            err_count++;
            end_sim();
         end
         m = (i == 3) ? 32'hFF800000 : 32'hFFFFFFFF;
         word &= m;
         chk_frame("frame", exp_frame(held) & m, word);
         chk_flag("int_sck_mode", ~i[0], o_status.int_sck_mode);
         cyc(6);
         chk_flag("converting", 1'b1, o_status.converting);
         if (i == 5)
         begin
            i_supply_ok = 1'b0;
            cyc(6);
            chk_flag("por_active", 1'b1, o_status.por_active);
            i_supply_ok = 1'b1;
         end
      end
      end_sim();
   end
endmodule // testbench

`default_nettype wire
